/* test/rpsc_strap_board.sv */
// board straps model: holds strap levels around external reset, then releases the pins
`timescale 1ns/1ps
module rpsc_strap_board (
   input  wire logic       holdStraps,           // straps driven by the board
   input  wire logic [7:0] lowWord,              // strap levels, low capture order
   input  wire logic [7:0] highWord,             // strap levels, high capture order
   output logic            serial0DataInPin,     // strap
   output logic            serial0DataOutPin,    // strap
   output logic            serial0ClockPin,      // strap
   output logic            serial0SelectPin,     // strap
   output logic            serial0EnablePin,     // strap
   output logic            serial1DataInPin,     // strap
   output logic            serial1DataOutPin,    // strap
   output logic            serial1ClockPin,      // strap
   output logic            serial1SelectPin,     // strap
   output logic            serial1EnablePin,     // strap
   output logic            hostPortChipSelectN,  // strap
   output logic            hostDataBit0Pin,      // strap
   output logic            extMemData16Pin,      // strap
   output logic            audio0TxFrameSync,    // strap
   output logic            audio0RxFrameSync,    // strap
   output logic            audio0Serializer0Pin  // strap
);
   logic [7:0] loPins;
   logic [7:0] hiPins;

   // released pins carry functional traffic, shown as the inverse so stale straps never match
   assign loPins = holdStraps ? lowWord : ~lowWord;
   assign hiPins = holdStraps ? highWord : ~highWord;

   // serial0 code on data-in, data-out, clock; host select low picks host boot
   assign {serial0DataInPin, serial0DataOutPin, serial0ClockPin, serial0SelectPin,
           serial0EnablePin, serial1DataInPin, serial1DataOutPin, serial1ClockPin} = loPins;
   assign {serial1SelectPin, serial1EnablePin, hostPortChipSelectN, hostDataBit0Pin,
           extMemData16Pin, audio0TxFrameSync, audio0RxFrameSync,
           audio0Serializer0Pin} = hiPins;
endmodule : rpsc_strap_board

/* test/rpsc_strap_capture_bench.sv */
// self-checking bench for the strap capture block over apb
`timescale 1ns/1ps
module rpsc_strap_capture_bench;
   logic        clk_sys = 1'b0;
   logic        resetn = 1'b0;
   logic        extResetN = 1'b0;
   logic        holdStraps = 1'b1;
   logic [7:0]  lowWord = 8'h00;
   logic [7:0]  highWord = 8'h20;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0;
   logic [31:0] prdata, bootVector, rd;
   logic        pready, pslverr, bootStart, romBootActive, captureValid, err;
   logic [2:0]  bootModeOut;
   logic        hostByteAddressSel, hostFullWidthSel, hostNonmuxedSel;
   logic        s0di, s0do, s0ck, s0se, s0en, s1di, s1do, s1ck, s1se, s1en;
   logic        hcsN, hd0, md16, txfs, rxfs, ser0;
   int          numErrors = 0;
   int          comparisons = 0;
   // strap table: five serial/flash codes, one unused code, two host boots
   logic [7:0]  loTab [8] = '{8'h4a, 8'h35, 8'h7c, 8'ha3, 8'he1, 8'h9c, 8'hd6, 8'h2b};
   logic [7:0]  hiTab [8] = '{8'hb5, 8'h6a, 8'h23, 8'hfc, 8'h3e, 8'h27, 8'h9f, 8'h40};
   logic [2:0]  modeTab [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0, 3'h0};

   always #4 clk_sys = ~clk_sys;

   rpsc_strap_board board (
      .holdStraps(holdStraps), .lowWord(lowWord), .highWord(highWord),
      .serial0DataInPin(s0di), .serial0DataOutPin(s0do), .serial0ClockPin(s0ck),
      .serial0SelectPin(s0se), .serial0EnablePin(s0en), .serial1DataInPin(s1di),
      .serial1DataOutPin(s1do), .serial1ClockPin(s1ck), .serial1SelectPin(s1se),
      .serial1EnablePin(s1en), .hostPortChipSelectN(hcsN), .hostDataBit0Pin(hd0),
      .extMemData16Pin(md16), .audio0TxFrameSync(txfs), .audio0RxFrameSync(rxfs),
      .audio0Serializer0Pin(ser0));

   rpsc_strap_capture dut (
      .clk_sys(clk_sys), .resetn(resetn), .extResetN(extResetN),
      .serial0DataInPin(s0di), .serial0DataOutPin(s0do), .serial0ClockPin(s0ck),
      .serial0SelectPin(s0se), .serial0EnablePin(s0en), .serial1DataInPin(s1di),
      .serial1DataOutPin(s1do), .serial1ClockPin(s1ck), .serial1SelectPin(s1se),
      .serial1EnablePin(s1en), .hostPortChipSelectN(hcsN), .hostDataBit0Pin(hd0),
      .extMemData16Pin(md16), .audio0TxFrameSync(txfs), .audio0RxFrameSync(rxfs),
      .audio0Serializer0Pin(ser0), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bootVector(bootVector), .bootStart(bootStart),
      .romBootActive(romBootActive), .bootModeOut(bootModeOut),
      .hostByteAddressSel(hostByteAddressSel), .hostFullWidthSel(hostFullWidthSel),
      .hostNonmuxedSel(hostNonmuxedSel), .captureValid(captureValid));

   // one comparison; unknowns never match
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         numErrors++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 64);
      if (n >= 64)
         check(32'h1, 32'h0, "pready timeout");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // waits for the fetch strobe after reset release, then sees it fall after one cycle
   task automatic wait_boot();
      int n;
      n = 0;
      while (bootStart !== 1'b1 && n < 6)
      begin
         @(posedge clk_sys);
         n++;
      end
      check({31'h0, bootStart}, 32'h1, "boot strobe");
      check(bootVector, rpsc_pkg::ROM_BOOT_ADDR, "boot vector");
      check({31'h0, romBootActive}, 32'h1, "rom loader owns boot");
      @(posedge clk_sys);
      check({31'h0, bootStart}, 32'h0, "boot strobe one cycle");
   endtask : wait_boot

   // pulses external reset with straps from entry i, then checks every view of them
   task automatic strap_boot(input int i);
      logic [2:0] hcfg;
      hcfg = hiTab[i][5] ? 3'b000 : loTab[i][7:5];
      @(posedge clk_sys);
      extResetN <= 1'b0;
      holdStraps <= 1'b1;
      lowWord <= loTab[i];
      highWord <= hiTab[i];
      repeat (3) @(posedge clk_sys);
      check({31'h0, captureValid}, 32'h0, "valid cleared in reset");
      extResetN <= 1'b1;
      @(posedge clk_sys);
      holdStraps <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check({31'h0, captureValid}, 32'h1, "valid after capture");
      check({29'h0, bootModeOut}, {29'h0, modeTab[i]}, "boot mode");
      check({29'h0, hostByteAddressSel, hostFullWidthSel, hostNonmuxedSel},
            {29'h0, hcfg}, "host config");
      apb(1'b0, rpsc_pkg::ADDR_CAP_LOW, 32'h0);
      check(rd, {24'h0, loTab[i]}, "low capture");
      check({31'h0, err}, 32'h0, "low capture error");
      apb(1'b0, rpsc_pkg::ADDR_CAP_HIGH, 32'h0);
      check(rd, {24'h0, hiTab[i]}, "high capture");
      apb(1'b0, rpsc_pkg::ADDR_STATUS, 32'h0);
      check(rd, {22'h0, 1'b0, 1'b1, 1'b0, modeTab[i], 1'b0, hcfg}, "status");
   endtask : strap_boot

   // closing report and verdict
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", comparisons, numErrors);
      if (numErrors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict

   // watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      #(8 * 20000);
      numErrors++;
      $display("[FAIL] %0t watchdog expired", $time);
      print_verdict();
   end

   // main sequence
   initial
   begin
      repeat (8) @(posedge clk_sys);
      resetn <= 1'b1;
      wait_boot();
      for (int i = 0; i < 8; i++)
         strap_boot(i);
      // captures ignore writes, unmapped space errors; reserved bits written zero
      apb(1'b1, rpsc_pkg::ADDR_CAP_LOW, 32'h0000_0055);
      check({31'h0, err}, 32'h0, "write low no error");
      apb(1'b1, rpsc_pkg::ADDR_CAP_HIGH, 32'h0000_00ff);
      apb(1'b0, rpsc_pkg::ADDR_CAP_LOW, 32'h0);
      check(rd, {24'h0, loTab[7]}, "low after write");
      apb(1'b0, rpsc_pkg::ADDR_CAP_HIGH, 32'h0);
      check(rd, {24'h0, hiTab[7]}, "high after write");
      apb(1'b0, rpsc_pkg::ADDR_CTRL + 32'h4, 32'h0);
      check({31'h0, err}, 32'h1, "unmapped error");
      // handoff from rom loader
      apb(1'b1, rpsc_pkg::ADDR_CTRL, 32'h1);
      @(posedge clk_sys);
      check({31'h0, romBootActive}, 32'h0, "handoff");
      apb(1'b0, rpsc_pkg::ADDR_STATUS, 32'h0);
      check(rd, {22'h0, 1'b1, 1'b1, 1'b0, 3'h0, 1'b0, loTab[7][7:5]}, "status handoff");
      // emulator or timer reset leaves captures alone
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check({31'h0, romBootActive}, 32'h1, "loader back in reset");
      resetn <= 1'b1;
      wait_boot();
      check({31'h0, captureValid}, 32'h1, "valid kept");
      check({29'h0, hostByteAddressSel, hostFullWidthSel, hostNonmuxedSel},
            {29'h0, loTab[7][7:5]}, "host config kept");
      apb(1'b0, rpsc_pkg::ADDR_CAP_LOW, 32'h0);
      check(rd, {24'h0, loTab[7]}, "low kept");
      apb(1'b0, rpsc_pkg::ADDR_CAP_HIGH, 32'h0);
      check(rd, {24'h0, hiTab[7]}, "high kept");
      apb(1'b0, rpsc_pkg::ADDR_CTRL, 32'h0);
      check(rd, 32'h0, "control reset");
      print_verdict();
   end
endmodule : rpsc_strap_capture_bench

/* verilog/rpsc_capture_word.sv */
// one word of strap capture flops with a one-cycle strap delay
`timescale 1ns/1ps
module rpsc_capture_word #(
   parameter int W = 8
) (
   input  wire logic         clk_sys,     // system clock
   input  wire logic         captureNow,  // one-cycle capture strobe
   input  wire logic         clearNow,    // held while external reset is low
   input  wire logic [W-1:0] strapIn,     // live strap pin levels
   output logic      [W-1:0] strapDly,    // straps one cycle old
   output logic      [W-1:0] captured     // held capture value
);
   typedef struct packed {
      logic [W-1:0] dly;
      logic [W-1:0] cap;
   } rpsc_cell_s;

   rpsc_cell_s st;
   rpsc_cell_s nxt;

   // the delayed copy holds the level from while reset was still low,
   // before pins can turn into outputs on the release edge
   always_comb
   begin
      nxt     = st;
      nxt.dly = strapIn;
      if (captureNow)
      begin
         nxt.cap = st.dly;
      end
      else if (clearNow)
      begin
         nxt.cap = '0;
      end
   end

   // no system reset here: only the external pin may disturb the capture
   always_ff @(posedge clk_sys)
   begin
      st <= nxt;
   end

   assign strapDly = st.dly;
   assign captured = st.cap;
endmodule : rpsc_capture_word

/* verilog/rpsc_pkg.sv */
// shared constants and types for the reset pin strap capture block
package rpsc_pkg;
   // register byte addresses on the apb
   localparam logic [31:0] ADDR_CAP_LOW  = 32'h4000_0000;
   localparam logic [31:0] ADDR_CAP_HIGH = 32'h4000_0004;
   localparam logic [31:0] ADDR_STATUS   = 32'h4000_0008;
   localparam logic [31:0] ADDR_CTRL     = 32'h4000_000c;

   // fixed hardware boot vector: internal rom base
   localparam logic [31:0] ROM_BOOT_ADDR = 32'h0000_0000;

   // capture word width and field positions
   localparam int          CAP_W         = 8;
   localparam int          CAPL_S0_DIN   = 7;
   localparam int          CAPL_S0_CLK   = 5;
   localparam int          CAPH_HOST_CS  = 5;

   // status register field positions
   localparam int          STAT_HCFG_LSB = 0;
   localparam int          STAT_MODE_LSB = 4;
   localparam int          STAT_DONE_BIT = 8;
   localparam int          STAT_HOFF_BIT = 9;

   // control register field position and value after reset
   localparam int          CTRL_HOFF_BIT = 0;
   localparam logic        CTRL_HOFF_RST = 1'b0;

   // strap codes on serial0 data-in, data-out, clock with host select high
   localparam logic [2:0]  STRAP_PFLASH  = 3'b010;
   localparam logic [2:0]  STRAP_SPI_MST = 3'b001;
   localparam logic [2:0]  STRAP_SPI_SLV = 3'b011;
   localparam logic [2:0]  STRAP_I2C_MST = 3'b101;
   localparam logic [2:0]  STRAP_I2C_SLV = 3'b111;

   // boot source as decoded from the captured straps
   typedef enum logic [2:0] {
      BOOT_HOST,
      BOOT_PFLASH,
      BOOT_SPI_MASTER,
      BOOT_SPI_SLAVE,
      BOOT_I2C_MASTER,
      BOOT_I2C_SLAVE,
      BOOT_INVALID
   } rpsc_boot_e;
endpackage : rpsc_pkg

/* verilog/rpsc_strap_capture.sv */
// reset pin strap capture with apb register access and boot decode
// Notes on behaviour
// - execution always starts from internal rom at address zero after reset
// - rom loader picks its boot mode by reading both capture registers
// - only external reset recaptures; emulator or timer resets leave captures alone
// - each bit latches its pin on the external reset rising edge, holds
// - low word bits 7..3: serial0 data-in, data-out, clock, select, enable
// - low word bits 2..0: serial1 data-in, data-out, clock
// - high word bits 7..5: serial1 select, serial1 enable, host chip select
// - high word bits 4..0: host d0, mem d16, tx fsync, rx fsync, serializer0
// - bits 31..8 reserved; software writes zeros there
// - host select low copies serial0 pins into host port config bits
// - serial boot offers spi and i2c, each as master or slave
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module rpsc_strap_capture (
   input  wire logic        clk_sys,             // 125 MHz system clock
   input  wire logic        resetn,              // any device reset, sync
   input  wire logic        extResetN,           // external reset pin level
   input  wire logic        serial0DataInPin,    // strap
   input  wire logic        serial0DataOutPin,   // strap
   input  wire logic        serial0ClockPin,     // strap
   input  wire logic        serial0SelectPin,    // strap
   input  wire logic        serial0EnablePin,    // strap
   input  wire logic        serial1DataInPin,    // strap
   input  wire logic        serial1DataOutPin,   // strap
   input  wire logic        serial1ClockPin,     // strap
   input  wire logic        serial1SelectPin,    // strap
   input  wire logic        serial1EnablePin,    // strap
   input  wire logic        hostPortChipSelectN, // strap, host select
   input  wire logic        hostDataBit0Pin,     // strap
   input  wire logic        extMemData16Pin,     // strap
   input  wire logic        audio0TxFrameSync,   // strap
   input  wire logic        audio0RxFrameSync,   // strap
   input  wire logic        audio0Serializer0Pin,// strap
   input  wire logic        psel,                // apb select
   input  wire logic        penable,             // apb access phase
   input  wire logic        pwrite,              // apb direction
   input  wire logic [31:0] paddr,               // apb byte address
   input  wire logic [31:0] pwdata,              // apb write data
   output logic      [31:0] prdata,              // apb read data
   output logic             pready,              // apb ready
   output logic             pslverr,             // apb error
   output logic      [31:0] bootVector,          // first fetch address
   output logic             bootStart,           // fetch start pulse
   output logic             romBootActive,       // loader still owns boot
   output logic      [2:0]  bootModeOut,         // decoded boot source
   output logic             hostByteAddressSel,  // host port config
   output logic             hostFullWidthSel,    // host port config
   output logic             hostNonmuxedSel,     // host port config
   output logic             captureValid         // straps captured
);
   typedef struct packed {
      logic                  extPinPrev;
      logic                  resetPrev;
      logic                  bootStart;
      logic [31:0]           bootAddr;
      logic [2:0]            hostCfg;
      logic                  capDone;
      logic                  handoff;
      rpsc_pkg::rpsc_boot_e  bootMode;
      logic [31:0]           rdata;
      logic                  slvErr;
   } rpsc_state_s;

   rpsc_state_s st;
   rpsc_state_s nxt;

   logic [rpsc_pkg::CAP_W-1:0] strapLow;
   logic [rpsc_pkg::CAP_W-1:0] strapHigh;
   logic [rpsc_pkg::CAP_W-1:0] dlyLow;
   logic [rpsc_pkg::CAP_W-1:0] dlyHigh;
   logic [rpsc_pkg::CAP_W-1:0] capLow;
   logic [rpsc_pkg::CAP_W-1:0] capHigh;
   logic                       pinRise;
   logic                       setupRd;
   logic                       accessWr;
   logic                       addrHit;
   logic [31:0]                readMux;

   // strap pin order inside each capture word
   assign strapLow  = {serial0DataInPin, serial0DataOutPin,
                       serial0ClockPin, serial0SelectPin,
                       serial0EnablePin,
                       serial1DataInPin, serial1DataOutPin,
                       serial1ClockPin};
   assign strapHigh = {serial1SelectPin, serial1EnablePin,
                       hostPortChipSelectN,
                       hostDataBit0Pin, extMemData16Pin,
                       audio0TxFrameSync, audio0RxFrameSync,
                       audio0Serializer0Pin};

   // release edge of the external pin; resetn alone never fires it
   assign pinRise = extResetN && !st.extPinPrev;

   // capture words, one cell each
   rpsc_capture_word #(
      .W          (rpsc_pkg::CAP_W)
   ) u_capLow (
      .clk_sys    (clk_sys),
      .captureNow (pinRise),
      .clearNow   (!extResetN),
      .strapIn    (strapLow),
      .strapDly   (dlyLow),
      .captured   (capLow)
   );

   rpsc_capture_word #(
      .W          (rpsc_pkg::CAP_W)
   ) u_capHigh (
      .clk_sys    (clk_sys),
      .captureNow (pinRise),
      .clearNow   (!extResetN),
      .strapIn    (strapHigh),
      .strapDly   (dlyHigh),
      .captured   (capHigh)
   );

   // boot source decode from captured straps; unused codes are illegal
   function automatic rpsc_pkg::rpsc_boot_e decodeMode(
      input logic       hostSelN,
      input logic [2:0] code
   );
      rpsc_pkg::rpsc_boot_e m;
      m = rpsc_pkg::BOOT_INVALID;
      if (!hostSelN)
      begin
         m = rpsc_pkg::BOOT_HOST;
      end
      else
      begin
         unique case (code)
            rpsc_pkg::STRAP_PFLASH:  m = rpsc_pkg::BOOT_PFLASH;
            rpsc_pkg::STRAP_SPI_MST: m = rpsc_pkg::BOOT_SPI_MASTER;
            rpsc_pkg::STRAP_SPI_SLV: m = rpsc_pkg::BOOT_SPI_SLAVE;
            rpsc_pkg::STRAP_I2C_MST: m = rpsc_pkg::BOOT_I2C_MASTER;
            rpsc_pkg::STRAP_I2C_SLV: m = rpsc_pkg::BOOT_I2C_SLAVE;
            default:                 m = rpsc_pkg::BOOT_INVALID;
         endcase
      end
      return m;
   endfunction : decodeMode

   // apb phase qualifiers; the slave never stretches the access
   assign setupRd  = psel && !penable && !pwrite;
   assign accessWr = psel && penable && pwrite;
   assign addrHit  = (paddr == rpsc_pkg::ADDR_CAP_LOW)  ||
                     (paddr == rpsc_pkg::ADDR_CAP_HIGH) ||
                     (paddr == rpsc_pkg::ADDR_STATUS)   ||
                     (paddr == rpsc_pkg::ADDR_CTRL);

   // read mux; reserved upper bits return zero
   always_comb
   begin
      readMux = 32'h0000_0000;
      if (paddr == rpsc_pkg::ADDR_CAP_LOW)
      begin
         readMux[rpsc_pkg::CAP_W-1:0] = capLow;
      end
      else if (paddr == rpsc_pkg::ADDR_CAP_HIGH)
      begin
         readMux[rpsc_pkg::CAP_W-1:0] = capHigh;
      end
      else if (paddr == rpsc_pkg::ADDR_STATUS)
      begin
         readMux[rpsc_pkg::STAT_HCFG_LSB +: 3] = st.hostCfg;
         readMux[rpsc_pkg::STAT_MODE_LSB +: 3] = st.bootMode;
         readMux[rpsc_pkg::STAT_DONE_BIT]      = st.capDone;
         readMux[rpsc_pkg::STAT_HOFF_BIT]      = st.handoff;
      end
      else if (paddr == rpsc_pkg::ADDR_CTRL)
      begin
         readMux[rpsc_pkg::CTRL_HOFF_BIT] = st.handoff;
      end
   end

   // next state; resetn is folded in here as a synchronous reset
   always_comb
   begin
      nxt            = st;
      nxt.extPinPrev = extResetN;
      nxt.resetPrev  = resetn;
      nxt.bootStart  = resetn && !st.resetPrev;
      // decode runs every cycle so the loader sees the live captures
      nxt.bootMode   = decodeMode(capHigh[rpsc_pkg::CAPH_HOST_CS],
                                  capLow[rpsc_pkg::CAPL_S0_DIN:
                                         rpsc_pkg::CAPL_S0_CLK]);
      // host config follows the capture edge, not the system reset
      if (pinRise)
      begin
         nxt.capDone = 1'b1;
         if (!dlyHigh[rpsc_pkg::CAPH_HOST_CS])
         begin
            nxt.hostCfg = dlyLow[rpsc_pkg::CAPL_S0_DIN:
                                 rpsc_pkg::CAPL_S0_CLK];
         end
         else
         begin
            nxt.hostCfg = 3'h0;
         end
      end
      else if (!extResetN)
      begin
         nxt.capDone = 1'b0;
         nxt.hostCfg = 3'h0;
      end
      // read data and error are set up in the setup cycle
      if (psel && !penable)
      begin
         nxt.slvErr = !addrHit;
         nxt.rdata  = setupRd ? readMux : 32'h0000_0000;
      end
      // only control is writable; capture and status writes drop
      if (accessWr && (paddr == rpsc_pkg::ADDR_CTRL))
      begin
         nxt.handoff = pwdata[rpsc_pkg::CTRL_HOFF_BIT];
      end
      // emulator and timer resets land here and leave captures intact
      if (!resetn)
      begin
         nxt.resetPrev = 1'b0;
         nxt.bootStart = 1'b0;
         nxt.bootAddr  = rpsc_pkg::ROM_BOOT_ADDR;
         nxt.handoff   = rpsc_pkg::CTRL_HOFF_RST;
         nxt.rdata     = 32'h0000_0000;
         nxt.slvErr    = 1'b0;
      end
   end

   // single state register
   always_ff @(posedge clk_sys)
   begin
      st <= nxt;
   end

   // outputs
   assign prdata             = st.rdata;
   assign pready             = 1'b1;
   assign pslverr            = st.slvErr;
   assign bootVector         = st.bootAddr;
   assign bootStart          = st.bootStart;
   assign romBootActive      = !st.handoff;
   assign bootModeOut        = st.bootMode;
   assign hostByteAddressSel = st.hostCfg[2];
   assign hostFullWidthSel   = st.hostCfg[1];
   assign hostNonmuxedSel    = st.hostCfg[0];
   assign captureValid       = st.capDone;

   // boot always begins at the rom base one cycle after release
   property p_boot_vector;
      @(posedge clk_sys) disable iff (!resetn)
      $rose(resetn) |=> bootStart && (bootVector == 32'h0000_0000)
                        ##1 !bootStart;
   endproperty
   a_boot_vector: assert property (p_boot_vector)
      else $error("boot does not start at rom base");

   // software reads of the low capture word return the captured bits
   property p_read_low;
      @(posedge clk_sys) disable iff (!resetn)
      (setupRd && paddr == rpsc_pkg::ADDR_CAP_LOW) |=>
         prdata == {24'h000000, $past(capLow)};
   endproperty
   a_read_low: assert property (p_read_low)
      else $error("low capture read data wrong");

   // with the pin high and no rise, captures never move
   property p_hold;
      @(posedge clk_sys) disable iff (!extResetN)
      (extResetN && !pinRise) |=> $stable(capLow) && $stable(capHigh);
   endproperty
   a_hold: assert property (p_hold)
      else $error("capture changed without external reset");

   // serial0 straps land in low bits 7..3
   property p_map_s0;
      @(posedge clk_sys) disable iff (!extResetN)
      pinRise |=> capLow[7:3] == {$past(serial0DataInPin, 2),
                                  $past(serial0DataOutPin, 2),
                                  $past(serial0ClockPin, 2),
                                  $past(serial0SelectPin, 2),
                                  $past(serial0EnablePin, 2)};
   endproperty
   a_map_s0: assert property (p_map_s0)
      else $error("serial0 capture mapping wrong");

   // serial1 data and clock straps land in low bits 2..0
   property p_map_s1;
      @(posedge clk_sys) disable iff (!extResetN)
      pinRise |=> capLow[2:0] == {$past(serial1DataInPin, 2),
                                  $past(serial1DataOutPin, 2),
                                  $past(serial1ClockPin, 2)};
   endproperty
   a_map_s1: assert property (p_map_s1)
      else $error("serial1 capture mapping wrong");

   // high word upper three bits
   property p_map_hi_top;
      @(posedge clk_sys) disable iff (!extResetN)
      pinRise |=> capHigh[7:5] == {$past(serial1SelectPin, 2),
                                   $past(serial1EnablePin, 2),
                                   $past(hostPortChipSelectN, 2)};
   endproperty
   a_map_hi_top: assert property (p_map_hi_top)
      else $error("high capture top bits wrong");

   // high word lower five bits
   property p_map_hi_low;
      @(posedge clk_sys) disable iff (!extResetN)
      pinRise |=> capHigh[4:0] == {$past(hostDataBit0Pin, 2),
                                   $past(extMemData16Pin, 2),
                                   $past(audio0TxFrameSync, 2),
                                   $past(audio0RxFrameSync, 2),
                                   $past(audio0Serializer0Pin, 2)};
   endproperty
   a_map_hi_low: assert property (p_map_hi_low)
      else $error("high capture low bits wrong");

   // capture reads never show anything above bit 7
   property p_reserved;
      @(posedge clk_sys) disable iff (!resetn)
      (setupRd && (paddr == rpsc_pkg::ADDR_CAP_LOW ||
                   paddr == rpsc_pkg::ADDR_CAP_HIGH)) |=>
         prdata[31:8] == 24'h000000;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved capture bits not zero");

   // host select low copies serial0 levels into the host config
   property p_host_cfg;
      @(posedge clk_sys) disable iff (!extResetN)
      (pinRise && !dlyHigh[rpsc_pkg::CAPH_HOST_CS]) |=>
         {hostByteAddressSel, hostFullWidthSel, hostNonmuxedSel}
            == capLow[7:5] && captureValid;
   endproperty
   a_host_cfg: assert property (p_host_cfg)
      else $error("host config not copied from straps");

   // straps for spi master decode to that mode one cycle later
   property p_mode_spi;
      @(posedge clk_sys) disable iff (!resetn)
      (capHigh[rpsc_pkg::CAPH_HOST_CS] && capLow[7:5] == 3'b001) |=>
         bootModeOut == rpsc_pkg::BOOT_SPI_MASTER;
   endproperty
   a_mode_spi: assert property (p_mode_spi)
      else $error("spi master strap decoded wrongly");

   // a write to the low capture word leaves it unchanged
   property p_write_drop;
      @(posedge clk_sys) disable iff (!resetn)
      (accessWr && extResetN && !pinRise &&
       paddr == rpsc_pkg::ADDR_CAP_LOW) |=> $stable(capLow) ##1 $stable(capLow);
   endproperty
   a_write_drop: assert property (p_write_drop)
      else $error("capture changed after write");

   // unmapped addresses answer with an error in the access phase
   property p_unmapped;
      @(posedge clk_sys) disable iff (!resetn)
      (psel && !penable && !addrHit) |=> pslverr && pready;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not flagged");
endmodule : rpsc_strap_capture
